// ---- inc/mss_cfg.svh ----
/*
  Constants for the master/slave synchronous serial port: register offsets,
  field positions, reset values and timing counts.
  Assumes a 100 MHz core clock and a byte-addressed APB with 32-bit data.
*/
`ifndef MSS_CFG_SVH
`define MSS_CFG_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define MSS_ADDR_CTRL1 8'h00
`define MSS_ADDR_CTRL2 8'h04
`define MSS_ADDR_FLAGS 8'h08
`define MSS_ADDR_DATA 8'h0C
`define MSS_ADDR_POP 8'h10
`define MSS_ADDR_EOF 8'h14

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define MSS_C1_RATE_LO 16
`define MSS_C1_RATE_HI 17
`define MSS_C2_TXEN 4
`define MSS_C2_RXEN 7
`define MSS_C2_MAEN 9
`define MSS_FL_RX_OVERRUN 0
`define MSS_FL_TX_UNDERFLOW 1
`define MSS_FL_RES_FRAME 2
`define MSS_FL_RES_VALID 3
`define MSS_FL_RX_EMPTY 4
`define MSS_FL_TX_FULL 5

// ----------------------------------------------------------------------------
// reset values, sizes and timing
// ----------------------------------------------------------------------------
`define MSS_RATE_RST 2'h0
`define MSS_FIFO_DEPTH 16
`define MSS_FIFO_AW 4
`define MSS_FIFO_W 16
`define MSS_HALF_THR 5'h08
`define MSS_LAST_BIT 3'h7
`define MSS_PRE_FRAME_BIT 3'h6
`define MSS_CLK_HZ 100000000
`define MSS_RATE0_BPS 128000
`define MSS_RATE1_BPS 64000
`define MSS_RATE2_BPS 32000
`define MSS_RATE3_BPS 16000
// half bit period in core cycles, rounded up so the bit rate never exceeds its figure
`define MSS_HALF_CYC(bps) ((`MSS_CLK_HZ + 2 * (bps) - 1) / (2 * (bps)))
`define MSS_DIV_W 12

`endif

// ---- inc/mss_pkg.sv ----
/*
  Types for the master/slave synchronous serial port.
  Assumes mss_cfg.svh is available on the include path.
*/
package mss_pkg;
  typedef enum logic [1:0] {TX_IDLE, TX_ARMED, TX_SHIFT} mss_tx_state_type;
  typedef enum logic {RX_IDLE, RX_SHIFT} mss_rx_state_type;
endpackage

// ---- verilog/mss_sync.sv ----
/*
  Two-flop synchroniser bank for pins that arrive from outside the clock domain.
  Assumes each bit is an independent level; no bus coherence is given.
*/
`timescale 1ns/1ns
`default_nettype none
module mss_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_reg;
      logic sync_reg;
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else if (ce) begin
          meta_reg <= d[i];
          sync_reg <= meta_reg;
        end
      end
      assign q[i] = sync_reg;
    end
  endgenerate
endmodule
`default_nettype wire

// ---- verilog/mss_fifo.sv ----
/*
  Sixteen-entry half-word FIFO with first-word fall-through output.
  Assumes the caller never relies on a push while full or a pop while empty;
  both are ignored here.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mss_cfg.svh"
module mss_fifo (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic push,
  input wire logic [`MSS_FIFO_W-1:0] din,
  input wire logic pop,
  output logic [`MSS_FIFO_W-1:0] dout,
  output logic full,
  output logic empty,
  output logic [`MSS_FIFO_AW:0] count
);
  logic [`MSS_FIFO_W-1:0] mem [`MSS_FIFO_DEPTH];
  logic [`MSS_FIFO_AW-1:0] wr_ptr_reg;
  logic [`MSS_FIFO_AW-1:0] rd_ptr_reg;
  logic [`MSS_FIFO_AW:0] count_reg;
  wire logic do_push = push & !full;
  wire logic do_pop = pop & !empty;

  assign full = count_reg[`MSS_FIFO_AW];
  assign empty = (count_reg == '0);
  assign count = count_reg;
  assign dout = mem[rd_ptr_reg];

  // storage holds no reset so it can map onto plain RAM
  always_ff @(posedge clock) begin
    if (ce && do_push) begin
      mem[wr_ptr_reg] <= din;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (ce) begin
      wr_ptr_reg <= wr_ptr_reg + (`MSS_FIFO_AW)'(do_push);
      rd_ptr_reg <= rd_ptr_reg + (`MSS_FIFO_AW)'(do_pop);
      count_reg <= count_reg + (`MSS_FIFO_AW + 1)'(do_push) - (`MSS_FIFO_AW + 1)'(do_pop);
    end
  end
endmodule
`default_nettype wire

// ---- verilog/mss_top.sv ----
/*
  Master/slave synchronous serial port with APB register access, sixteen
  half-word FIFOs each way, residual byte recovery and error flags.
  Assumes the link pins are resolved outside from the output enables, and
  that the link clock is slow enough to be sampled by the 100 MHz core clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mss_cfg.svh"

// Contract
// - separate 16 half-word FIFOs; rx half-full and tx half-empty interrupts
// - slave: clock and both frame syncs input; master: drives them; rx always input
// - master operation when control-two bit 9 is one, else slave
// - bits 4 and 7 enable tx and rx; both clear disables the port
// - each byte preceded by a one-clock frame sync one clock before its MSB
// - bytes travel MSB first only
// - master bit clock chosen by control-one bits 17:16, at most 128 kbit/s
// - enable writes take effect one serial clock later; readback shows that state
// - FIFO port uses low 16 bits only; tx writes always carry two bytes
// - received bytes enter the FIFO in pairs; an odd byte is held back
// - residual valid and frame flags set together; valid clears on pop or frame
// - any write to the pop location pushes the held byte
// - residual overtaken by reception lands in the next half-word high byte
// - each side moves a byte on eight clocks after its own frame sync
// - back-to-back frame syncs are eight clocks apart, on the previous D0
// - as master the bit clock never stops between bytes
// - rx overflow sets a flag; any write to the end-of-frame location clears it
// - tx running dry sets a flag; writing tx data clears it (set only as slave here; as master no tx frame sync goes out when dry)
// - data change on rising clock, sampled on falling; polarity fixed
// - tx line released whenever no byte is being sent
module mss_top
  import mss_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic CLOCK_EN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SERIAL_BIT_CLOCK_IN,
  output logic SERIAL_BIT_CLOCK_OUT,
  output logic SERIAL_BIT_CLOCK_OE,
  input wire logic TX_FRAME_SYNC_IN,
  output logic TX_FRAME_SYNC_OUT,
  output logic TX_FRAME_SYNC_OE,
  input wire logic RX_FRAME_SYNC_IN,
  output logic RX_FRAME_SYNC_OUT,
  output logic RX_FRAME_SYNC_OE,
  input wire logic SERIAL_RX_LINE,
  output logic SERIAL_TX_LINE_OUT,
  output logic SERIAL_TX_LINE_OE,
  output logic RX_HALF_FULL_IRQ,
  output logic TX_HALF_EMPTY_IRQ
);
  // --------------------------------------------------------------------------
  // decode helpers and timing constants
  // --------------------------------------------------------------------------
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    return addr[7:2] == off[7:2];
  endfunction

  localparam logic [`MSS_DIV_W-1:0] HALF0 = `MSS_DIV_W'(`MSS_HALF_CYC(`MSS_RATE0_BPS));
  localparam logic [`MSS_DIV_W-1:0] HALF1 = `MSS_DIV_W'(`MSS_HALF_CYC(`MSS_RATE1_BPS));
  localparam logic [`MSS_DIV_W-1:0] HALF2 = `MSS_DIV_W'(`MSS_HALF_CYC(`MSS_RATE2_BPS));
  localparam logic [`MSS_DIV_W-1:0] HALF3 = `MSS_DIV_W'(`MSS_HALF_CYC(`MSS_RATE3_BPS));

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic [1:0] rate_reg;
  logic maen_reg;
  logic txen_req_reg;
  logic rxen_req_reg;
  logic txen_reg;
  logic rxen_reg;
  logic [`MSS_DIV_W-1:0] div_cnt_reg;
  logic div_clk_reg;
  logic [2:0] mbit_reg;
  logic txfs_reg;
  logic rxfs_reg;
  logic clk_prev_reg;
  mss_tx_state_type tx_state_reg;
  logic [2:0] tx_cnt_reg;
  logic [7:0] tx_sh_reg;
  logic tx_line_reg;
  logic tx_oe_reg;
  logic tx_byte_sel_reg;
  mss_rx_state_type rx_state_reg;
  logic [2:0] rx_cnt_reg;
  logic [7:0] rx_sh_reg;
  logic res_have_reg;
  logic [7:0] res_byte_reg;
  logic res_valid_reg;
  logic res_frame_reg;
  logic overrun_reg;
  logic underflow_reg;
  logic rx_irq_reg;
  logic tx_irq_reg;

  // --------------------------------------------------------------------------
  // pin synchronisers: clock, tx frame, rx frame, rx data
  // --------------------------------------------------------------------------
  logic [3:0] pin_s;
  mss_sync #(.WIDTH(4)) u_sync (
    .clock(CLOCK),
    .reset_n(RESET_N),
    .ce(CLOCK_EN),
    .d({SERIAL_RX_LINE, RX_FRAME_SYNC_IN, TX_FRAME_SYNC_IN, SERIAL_BIT_CLOCK_IN}),
    .q(pin_s)
  );

  // --------------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------------
  wire logic apb_acc = PSEL & PENABLE & !pready_reg;
  wire logic apb_done = PSEL & PENABLE & pready_reg;
  wire logic apb_wr = apb_done & PWRITE;
  wire logic apb_rd = apb_done & !PWRITE;
  wire logic mapped = hit(PADDR, `MSS_ADDR_CTRL1) | hit(PADDR, `MSS_ADDR_CTRL2)
                    | hit(PADDR, `MSS_ADDR_FLAGS) | hit(PADDR, `MSS_ADDR_DATA)
                    | hit(PADDR, `MSS_ADDR_POP) | hit(PADDR, `MSS_ADDR_EOF);
  wire logic wr_ctrl1 = apb_wr & hit(PADDR, `MSS_ADDR_CTRL1);
  wire logic wr_ctrl2 = apb_wr & hit(PADDR, `MSS_ADDR_CTRL2);
  wire logic wr_data = apb_wr & hit(PADDR, `MSS_ADDR_DATA);
  wire logic wr_pop = apb_wr & hit(PADDR, `MSS_ADDR_POP);
  wire logic wr_eof = apb_wr & hit(PADDR, `MSS_ADDR_EOF);

  // --------------------------------------------------------------------------
  // FIFOs
  // --------------------------------------------------------------------------
  logic [15:0] tx_dout;
  logic [15:0] rx_dout;
  logic [15:0] rx_din;
  logic tx_full;
  logic tx_empty;
  logic rx_full;
  logic rx_empty;
  logic [4:0] tx_count;
  logic [4:0] rx_count;
  logic tx_pop;
  logic rx_push;
  wire logic rx_pop = apb_rd & hit(PADDR, `MSS_ADDR_DATA) & !rx_empty;

  mss_fifo u_tx_fifo (
    .clock(CLOCK),
    .reset_n(RESET_N),
    .ce(CLOCK_EN),
    .push(wr_data),
    .din(PWDATA[15:0]),
    .pop(tx_pop),
    .dout(tx_dout),
    .full(tx_full),
    .empty(tx_empty),
    .count(tx_count)
  );

  mss_fifo u_rx_fifo (
    .clock(CLOCK),
    .reset_n(RESET_N),
    .ce(CLOCK_EN),
    .push(rx_push),
    .din(rx_din),
    .pop(rx_pop),
    .dout(rx_dout),
    .full(rx_full),
    .empty(rx_empty),
    .count(rx_count)
  );

  // --------------------------------------------------------------------------
  // bit clock: own divider as master, sampled pin edges as slave
  // --------------------------------------------------------------------------
  wire logic [`MSS_DIV_W-1:0] half_sel = (rate_reg == 2'h0) ? HALF0 :
                                         (rate_reg == 2'h1) ? HALF1 :
                                         (rate_reg == 2'h2) ? HALF2 : HALF3;
  // keeps running while any enable is pending, so a new enable can land
  wire logic div_run = maen_reg & (txen_req_reg | rxen_req_reg | txen_reg | rxen_reg);
  wire logic div_wrap = div_run & (div_cnt_reg == half_sel - `MSS_DIV_W'(1));
  wire logic s_rise = pin_s[0] & !clk_prev_reg;
  wire logic s_fall = !pin_s[0] & clk_prev_reg;
  wire logic bclk_rise = maen_reg ? (div_wrap & !div_clk_reg) : s_rise;
  wire logic bclk_fall = maen_reg ? (div_wrap & div_clk_reg) : s_fall;
  wire logic tx_fs = maen_reg ? txfs_reg : pin_s[1];
  wire logic rx_fs = maen_reg ? rxfs_reg : pin_s[2];
  wire logic rx_bit = pin_s[3];
  wire logic tx_have = !tx_empty | tx_byte_sel_reg;

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      div_cnt_reg <= '0;
      div_clk_reg <= 1'b0;
      mbit_reg <= 3'h0;
      txfs_reg <= 1'b0;
      rxfs_reg <= 1'b0;
      clk_prev_reg <= 1'b0;
    end else if (CLOCK_EN) begin
      clk_prev_reg <= pin_s[0];
      if (!div_run) begin
        div_cnt_reg <= '0;
        div_clk_reg <= 1'b0;
      end else if (div_wrap) begin
        div_cnt_reg <= '0;
        div_clk_reg <= !div_clk_reg;
      end else begin
        div_cnt_reg <= div_cnt_reg + `MSS_DIV_W'(1);
      end
      if (!maen_reg) begin
        txfs_reg <= 1'b0;
        rxfs_reg <= 1'b0;
      end else if (bclk_rise) begin
        mbit_reg <= mbit_reg + 3'h1;
        // pulse lies on the D0 slot of the byte before, eight clocks apart
        txfs_reg <= (mbit_reg == `MSS_PRE_FRAME_BIT) & txen_reg & tx_have;
        rxfs_reg <= (mbit_reg == `MSS_PRE_FRAME_BIT) & rxen_reg;
      end
    end
  end

  // --------------------------------------------------------------------------
  // control registers; enables move on a serial clock edge only
  // --------------------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      rate_reg <= `MSS_RATE_RST;
      maen_reg <= 1'b0;
      txen_req_reg <= 1'b0;
      rxen_req_reg <= 1'b0;
      txen_reg <= 1'b0;
      rxen_reg <= 1'b0;
    end else if (CLOCK_EN) begin
      if (wr_ctrl1) begin
        rate_reg <= PWDATA[`MSS_C1_RATE_HI:`MSS_C1_RATE_LO];
      end
      if (wr_ctrl2) begin
        maen_reg <= PWDATA[`MSS_C2_MAEN];
        txen_req_reg <= PWDATA[`MSS_C2_TXEN];
        rxen_req_reg <= PWDATA[`MSS_C2_RXEN];
      end
      if (bclk_rise) begin
        txen_reg <= txen_req_reg;
        rxen_reg <= rxen_req_reg;
      end
    end
  end

  // --------------------------------------------------------------------------
  // transmitter: armed by a frame seen on a fall, shifts on rises
  // --------------------------------------------------------------------------
  wire logic tx_load = bclk_rise & (tx_state_reg == TX_ARMED);
  wire logic [7:0] tx_byte = !tx_have ? 8'h00 :
                             tx_byte_sel_reg ? tx_dout[7:0] : tx_dout[15:8];
  assign tx_pop = tx_load & tx_byte_sel_reg;

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      tx_state_reg <= TX_IDLE;
      tx_cnt_reg <= 3'h0;
      tx_sh_reg <= 8'h00;
      tx_line_reg <= 1'b0;
      tx_oe_reg <= 1'b0;
      tx_byte_sel_reg <= 1'b0;
    end else if (CLOCK_EN) begin
      if (!txen_reg) begin
        tx_state_reg <= TX_IDLE;
        tx_oe_reg <= 1'b0;
      end else if (bclk_fall && tx_fs) begin
        tx_state_reg <= TX_ARMED;
      end else if (bclk_rise) begin
        case (tx_state_reg)
          TX_ARMED: begin
            tx_sh_reg <= tx_byte;
            tx_line_reg <= tx_byte[7];
            tx_oe_reg <= 1'b1;
            tx_cnt_reg <= 3'h0;
            tx_state_reg <= TX_SHIFT;
            if (tx_have) begin
              tx_byte_sel_reg <= !tx_byte_sel_reg;
            end
          end
          TX_SHIFT: begin
            if (tx_cnt_reg == `MSS_LAST_BIT) begin
              tx_oe_reg <= 1'b0;
              tx_state_reg <= TX_IDLE;
            end else begin
              tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
              tx_line_reg <= tx_sh_reg[6];
              tx_cnt_reg <= tx_cnt_reg + 3'h1;
            end
          end
          default: begin
            tx_oe_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // receiver: samples on falls for eight clocks after its frame sync
  // --------------------------------------------------------------------------
  wire logic [7:0] rx_byte = {rx_sh_reg[6:0], rx_bit};
  wire logic rx_done = bclk_fall & (rx_state_reg == RX_SHIFT) & (rx_cnt_reg == `MSS_LAST_BIT);
  wire logic new_frame = bclk_fall & rx_fs & rxen_reg;
  wire logic pair_push = rx_done & res_have_reg;
  // a pop that meets a completed pair in the same cycle loses its push
  assign rx_push = pair_push | wr_pop;
  assign rx_din = pair_push ? {res_byte_reg, rx_byte} : {res_byte_reg, 8'h00};

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      rx_state_reg <= RX_IDLE;
      rx_cnt_reg <= 3'h0;
      rx_sh_reg <= 8'h00;
    end else if (CLOCK_EN) begin
      if (!rxen_reg) begin
        rx_state_reg <= RX_IDLE;
      end else if (new_frame) begin
        rx_state_reg <= RX_SHIFT;
        rx_cnt_reg <= 3'h0;
        if (rx_state_reg == RX_SHIFT) begin
          rx_sh_reg <= rx_byte;
        end
      end else if (bclk_fall) begin
        case (rx_state_reg)
          RX_SHIFT: begin
            rx_sh_reg <= rx_byte;
            rx_cnt_reg <= rx_cnt_reg + 3'h1;
            if (rx_cnt_reg == `MSS_LAST_BIT) begin
              rx_state_reg <= RX_IDLE;
            end
          end
          default: begin
            rx_state_reg <= RX_IDLE;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // residual byte and error flags; a hardware set beats any clear
  // --------------------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      res_have_reg <= 1'b0;
      res_byte_reg <= 8'h00;
      res_valid_reg <= 1'b0;
      res_frame_reg <= 1'b0;
      overrun_reg <= 1'b0;
      underflow_reg <= 1'b0;
    end else if (CLOCK_EN) begin
      if (rx_done) begin
        res_have_reg <= !res_have_reg;
        if (!res_have_reg) begin
          res_byte_reg <= rx_byte;
        end
      end else if (wr_pop && res_frame_reg) begin
        res_have_reg <= 1'b0;
      end
      if (rx_done && !res_have_reg) begin
        res_valid_reg <= 1'b1;
        res_frame_reg <= 1'b1;
      end else begin
        if (new_frame || wr_pop || pair_push) begin
          res_valid_reg <= 1'b0;
        end
        if (new_frame || pair_push) begin
          res_frame_reg <= 1'b0;
        end
      end
      if (rx_push && rx_full) begin
        overrun_reg <= 1'b1;
      end else if (wr_eof) begin
        overrun_reg <= 1'b0;
      end
      if (tx_load && !tx_have) begin
        underflow_reg <= 1'b1;
      end else if (wr_data) begin
        underflow_reg <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // read mux and bus answer, one wait state on every access
  // --------------------------------------------------------------------------
  wire logic [31:0] rd_ctrl1 = {14'h0000, rate_reg, 16'h0000};
  wire logic [31:0] rd_ctrl2 = {22'h000000, maen_reg, 1'b0, rxen_reg, 2'h0, txen_reg, 4'h0};
  wire logic [31:0] rd_flags = {26'h0000000, tx_full, rx_empty, res_valid_reg,
                                res_frame_reg, underflow_reg, overrun_reg};
  wire logic [31:0] rd_data = rx_empty ? 32'h00000000 : {16'h0000, rx_dout};
  wire logic [31:0] rd_mux = hit(PADDR, `MSS_ADDR_CTRL1) ? rd_ctrl1 :
                             hit(PADDR, `MSS_ADDR_CTRL2) ? rd_ctrl2 :
                             hit(PADDR, `MSS_ADDR_FLAGS) ? rd_flags :
                             hit(PADDR, `MSS_ADDR_DATA) ? rd_data : 32'h00000000;

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      rx_irq_reg <= 1'b0;
      tx_irq_reg <= 1'b0;
    end else if (CLOCK_EN) begin
      pready_reg <= apb_acc;
      pslverr_reg <= apb_acc & !mapped;
      if (apb_acc) begin
        prdata_reg <= PWRITE ? 32'h00000000 : rd_mux;
      end
      rx_irq_reg <= (rx_count >= `MSS_HALF_THR);
      tx_irq_reg <= txen_reg & (tx_count <= `MSS_HALF_THR);
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign PREADY = pready_reg;
  assign PSLVERR = pslverr_reg;
  assign PRDATA = prdata_reg;
  assign SERIAL_BIT_CLOCK_OUT = div_clk_reg;
  assign SERIAL_BIT_CLOCK_OE = maen_reg;
  assign TX_FRAME_SYNC_OUT = txfs_reg;
  assign TX_FRAME_SYNC_OE = maen_reg;
  assign RX_FRAME_SYNC_OUT = rxfs_reg;
  assign RX_FRAME_SYNC_OE = maen_reg;
  assign SERIAL_TX_LINE_OUT = tx_line_reg;
  assign SERIAL_TX_LINE_OE = tx_oe_reg;
  assign RX_HALF_FULL_IRQ = rx_irq_reg;
  assign TX_HALF_EMPTY_IRQ = tx_irq_reg;
endmodule
`default_nettype wire

// ---- dv/mss_props.sv ----
/* Port checker for mss_top.
   Assumes CLOCK_EN high; bound to every mss_top below. */
`timescale 1ns/1ns
`default_nettype none
`include "mss_cfg.svh"
module mss_props (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic SERIAL_BIT_CLOCK_IN,
  input wire logic SERIAL_BIT_CLOCK_OE,
  input wire logic TX_FRAME_SYNC_IN,
  input wire logic TX_FRAME_SYNC_OE,
  input wire logic RX_FRAME_SYNC_OE,
  input wire logic SERIAL_TX_LINE_OUT,
  input wire logic SERIAL_TX_LINE_OE
);
  logic bclk_q;
  logic [7:0] rises;
  logic [7:0] fs_age;
  logic [7:0] since_rise;
  wire rise_now = SERIAL_BIT_CLOCK_IN && !bclk_q;
  wire ma_bit = PWDATA[`MSS_C2_MAEN];
  wire slave = !SERIAL_BIT_CLOCK_OE;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  // saturating ages so a long idle never wraps into a false match
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      bclk_q <= 1'b0;
      rises <= 8'h00;
      fs_age <= 8'hFF;
      since_rise <= 8'hFF;
    end else begin
      bclk_q <= SERIAL_BIT_CLOCK_IN;
      rises <= $rose(SERIAL_TX_LINE_OE) ? 8'h00 : rises + {7'h00, rise_now};
      fs_age <= TX_FRAME_SYNC_IN ? 8'h00 : fs_age + {7'h00, fs_age != 8'hFF};
      since_rise <= rise_now ? 8'h00 : since_rise + {7'h00, since_rise != 8'hFF};
    end
  end
  sequence s_answer;
    !PREADY ##1 PREADY;
  endsequence
  a_ready_wait: assert property ($rose(PENABLE) && PSEL |-> s_answer)
    else $error("ready not after one wait state");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_slverr_map: assert property (PSEL && PENABLE && PREADY |-> PSLVERR == (PADDR > 8'h17))
    else $error("error response on wrong address");
  a_master_sel: assert property (
    PSEL && PENABLE && PREADY && PWRITE && PADDR == `MSS_ADDR_CTRL2
    |=> SERIAL_BIT_CLOCK_OE == $past(ma_bit)) else $error("master select wrong");
  a_dir_tied: assert property (
    TX_FRAME_SYNC_OE == SERIAL_BIT_CLOCK_OE && RX_FRAME_SYNC_OE == SERIAL_BIT_CLOCK_OE)
    else $error("pin directions disagree");
  a_fs_lead: assert property (
    $rose(SERIAL_TX_LINE_OE) && slave |-> fs_age inside {[1:8]})
    else $error("byte not one clock after frame sync");
  a_byte_span: assert property (
    $fell(SERIAL_TX_LINE_OE) && slave |-> rises[2:0] == 3'h0 && rises != 8'h00)
    else $error("tx enable not whole bytes");
  a_tx_edge: assert property (
    $changed(SERIAL_TX_LINE_OUT) && SERIAL_TX_LINE_OE && slave |-> since_rise <= 8'd6)
    else $error("tx data moved away from rising edge");
endmodule
bind mss_top mss_props u_props (.*);
`default_nettype wire

// ---- dv/mss_node.sv ----
/* External link master for slave-mode runs.
   Assumes the bench floats the tx line while it is released. */
`timescale 1ns/1ns
`default_nettype none
module mss_node (
  output logic bclk,
  output logic fs,
  output logic rxd,
  input wire logic txd
);
  initial begin
    bclk = 1'b0;
    fs = 1'b0;
    rxd = 1'b0;
  end
  // clock runs only inside a call and parks low between calls
  task automatic xfer(input logic [15:0] d, input int nb, output logic [15:0] q);
    for (int i = -1; i <= 8 * nb + 1; i++) begin
      #62 bclk = 1'b1;
      fs = i >= 0 && i % 8 == 0 && i < 8 * nb;
      rxd = (i > 0 && i <= 8 * nb) ? d[16 - i] : ~rxd;
      #63 bclk = 1'b0;
      if (i > 0 && i <= 8 * nb) q[16 - i] = txd;
    end
  endtask
endmodule
`default_nettype wire

// ---- dv/mss_top_tb.sv ----
/* Bench for mss_top: APB tasks reach the registers, mss_node plays the link.
   Assumes mss_cfg.svh on the include path. */
`timescale 1ns/1ns
`default_nettype none
`include "mss_cfg.svh"
module mss_top_tb;
  logic CLOCK, RESET_N, CLOCK_EN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, slv, last;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic SERIAL_BIT_CLOCK_OUT, SERIAL_BIT_CLOCK_OE, TX_FRAME_SYNC_OUT, TX_FRAME_SYNC_OE;
  logic RX_FRAME_SYNC_OUT, RX_FRAME_SYNC_OE, SERIAL_TX_LINE_OUT, SERIAL_TX_LINE_OE;
  logic RX_HALF_FULL_IRQ, TX_HALF_EMPTY_IRQ, SERIAL_RX_LINE, nbclk, nfs;
  logic [15:0] q;
  int err_total, n_compared, edges;
  wire SERIAL_BIT_CLOCK_IN = SERIAL_BIT_CLOCK_OE ? SERIAL_BIT_CLOCK_OUT : nbclk;
  wire TX_FRAME_SYNC_IN = TX_FRAME_SYNC_OE ? TX_FRAME_SYNC_OUT : nfs;
  wire RX_FRAME_SYNC_IN = RX_FRAME_SYNC_OE ? RX_FRAME_SYNC_OUT : nfs;
  wire tx_line = SERIAL_TX_LINE_OE ? SERIAL_TX_LINE_OUT : 1'bz;
  mss_top DUT (.*);
  mss_node node (.bclk(nbclk), .fs(nfs), .rxd(SERIAL_RX_LINE), .txd(tx_line));
  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    for (int n = 0; n < 50 && PREADY !== 1'b1; n++) @(posedge CLOCK);
    if (PREADY !== 1'b1) err_total++;
    rd = PRDATA;
    slv = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, e, input string s);
    apb(1'b0, a, 32'h0);
    chk(s, e, rd & m);
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #500000;
    err_total++;
    wrap_up();
  end
  initial begin
    {RESET_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    CLOCK_EN = 1'b1;
    err_total = 0;
    n_compared = 0;
    edges = 0;
    repeat (10) @(posedge CLOCK);
    RESET_N <= 1'b1;
    rchk(`MSS_ADDR_FLAGS, 32'h3F, 32'h10, "reset flags");
    apb(1'b1, `MSS_ADDR_CTRL2, 32'h90);
    rchk(`MSS_ADDR_CTRL2, 32'h290, 32'h0, "early enables");
    node.xfer(16'h0, 0, q);
    rchk(`MSS_ADDR_CTRL2, 32'h290, 32'h90, "late enables");
    apb(1'b1, `MSS_ADDR_DATA, 32'hFFFF_A55A);
    node.xfer(16'h3CC3, 2, q);
    chk("tx pair", 32'hA55A, {16'h0, q});
    rchk(`MSS_ADDR_DATA, 32'hFFFF, 32'h3CC3, "rx pair");
    node.xfer(16'h8100, 1, q);
    chk("dry byte", 32'h0, {24'h0, q[15:8]});
    rchk(`MSS_ADDR_FLAGS, 32'hE, 32'hE, "odd flags");
    apb(1'b1, `MSS_ADDR_POP, 32'h1234);
    rchk(`MSS_ADDR_FLAGS, 32'hC, 32'h4, "pop flags");
    rchk(`MSS_ADDR_DATA, 32'hFFFF, 32'h8100, "residual");
    apb(1'b1, `MSS_ADDR_DATA, 32'h1122);
    rchk(`MSS_ADDR_FLAGS, 32'h2, 32'h0, "underflow clear");
    node.xfer(16'h5500, 1, q);
    node.xfer(16'h6600, 1, q);
    chk("second tx", 32'h22, {24'h0, q[15:8]});
    rchk(`MSS_ADDR_DATA, 32'hFFFF, 32'h5566, "late pair");
    rchk(`MSS_ADDR_EOF + 8'h0C, 32'h0, 32'h0, "unmapped");
    chk("slverr", 32'h1, {31'h0, slv});
    for (int i = 0; i < 17; i++) begin
      node.xfer(16'hABCD, 2, q);
      if (i == 7)
        chk("half irqs", 32'h3, {30'h0, RX_HALF_FULL_IRQ, TX_HALF_EMPTY_IRQ});
    end
    rchk(`MSS_ADDR_FLAGS, 32'h1, 32'h1, "overrun");
    apb(1'b1, `MSS_ADDR_EOF, 32'h0);
    rchk(`MSS_ADDR_FLAGS, 32'h1, 32'h0, "overrun clear");
    apb(1'b1, `MSS_ADDR_CTRL2, 32'h290);
    @(posedge CLOCK);
    chk("master oe", 32'h1, {31'h0, SERIAL_BIT_CLOCK_OE});
    last = SERIAL_BIT_CLOCK_OUT;
    for (int i = 0; i < 3910; i++) begin
      @(negedge CLOCK);
      edges += int'(SERIAL_BIT_CLOCK_OUT ^ last);
      last = SERIAL_BIT_CLOCK_OUT;
    end
    chk("clock edges", 32'h1, {31'h0, edges inside {[9:11]}});
    wrap_up();
  end
endmodule
`default_nettype wire
